// file: hw/fwsb_pkg.sv
// Purpose: Constants for the flash status polling controller (host side).
// Assumes: 200 MHz clock; flash is an asynchronous parallel NOR part.
// Notes: Host registers are our own; the flash itself has no registers.

`default_nettype none
package fwsb_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Register indices of the host port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_POLLS = 4'h5;
  // Control fields
  localparam int unsigned CTRL_CMD_LSB = 0;
  localparam int unsigned CTRL_GO_BIT = 4;
  localparam int unsigned CTRL_USE_POLL_BIT = 5;
  // Commands
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_POLL = 3'h2;
  localparam logic [2:0] CMD_RESET = 3'h3;
  localparam logic [2:0] CMD_WINDOW = 3'h4;
  // Status fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_FAIL = 2;
  localparam int unsigned ST_WINDOW = 3;
  localparam int unsigned ST_TIMEOUT = 4;
  // Flash data bit positions
  localparam int unsigned BIT_POLL = 7;
  localparam int unsigned BIT_TOGGLE_ONE = 6;
  localparam int unsigned BIT_LIMIT_FAIL = 5;
  localparam int unsigned BIT_ERASE_WINDOW = 3;
  localparam int unsigned BIT_TOGGLE_TWO = 2;
  localparam logic [7:0] RESET_CMD_DATA = 8'hf0;
  // Bus timing: 90 ns slowest access, 90 ns write pulse, 10 ns output hold for status reads
  localparam int unsigned T_ACC_NS = 90;
  localparam int unsigned T_WP_NS = 90;
  localparam int unsigned T_OEH_NS = 10;
  localparam logic [5:0] ACC_CYC = 6'((T_ACC_NS * CLK_MHZ + 999) / 1000 + 2);
  localparam logic [5:0] WP_CYC = 6'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [5:0] OEH_CYC = 6'((T_OEH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] POLL_LIMIT_RST = 32'h00ff_ffff;
  typedef enum logic [2:0] {
    FWSB_IDLE = 3'b000, FWSB_SETUP = 3'b001, FWSB_STROBE = 3'b011,
    FWSB_HOLD = 3'b010, FWSB_EVAL = 3'b110
  } fwsb_state_e;
endpackage : fwsb_pkg
`default_nettype wire

// file: hw/fwsb_sync.sv
// Purpose: Two-stage synchroniser for the flash data inputs.
// Assumes: Data pins are asynchronous to clock.
// Notes: First stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module fwsb_sync (
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  logic [7:0] meta_reg;
  always_ff @(posedge clock) begin
    if (clock_enable) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : fwsb_sync
`default_nettype wire

// file: hw/fwsb_cmp.sv
// Purpose: Compares two status samples and judges toggle bit one or the poll bit.
// Assumes: The prev sample is the last read for toggle bit one, the byte written for the poll bit.
// Notes: Registered result, one cycle after load.
`timescale 1ns/1ps
`default_nettype none
module fwsb_cmp (
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic load,
  input wire logic use_poll_bit,
  input wire logic [7:0] prev,
  input wire logic [7:0] curr,
  output logic toggling,
  output logic fail_seen
);
  always_ff @(posedge clock) begin
    if (clock_enable && load) begin
      toggling <= use_poll_bit ? (curr[fwsb_pkg::BIT_POLL] != prev[fwsb_pkg::BIT_POLL])
                               : (curr[fwsb_pkg::BIT_TOGGLE_ONE] != prev[fwsb_pkg::BIT_TOGGLE_ONE]);
      fail_seen <= curr[fwsb_pkg::BIT_LIMIT_FAIL];
    end
  end
endmodule : fwsb_cmp
`default_nettype wire

// file: hw/fwsb_host.sv
// Purpose: Host controller that drives flash bus cycles and polls status.
// Assumes: Flash pins are active-low strobes plus a bidirectional data bus.
// Notes: Software starts one operation at a time through CTRL.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fwsb_host (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [18:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe
);
  // ****************************************
  // Host registers
  // ****************************************
  logic [18:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic [7:0] prev_reg;
  logic [2:0] cmd_reg;
  logic use_poll_reg;
  logic busy_reg;
  logic done_reg;
  logic fail_reg;
  logic window_reg;
  logic timeout_reg;
  logic [31:0] poll_limit_reg;
  logic [31:0] poll_count_reg;
  logic [5:0] cyc_reg;
  logic first_reg;
  logic recheck_reg;
  logic eval_wait_reg;
  fwsb_pkg::fwsb_state_e state_reg;
  logic [7:0] dq_sync;
  logic toggling;
  logic fail_seen;
  logic go;
  logic is_read;
  logic [7:0] cmp_ref;
  logic strobe_end;
  logic hold_end;
  logic single_end;
  logic eval_now;
  logic finish_fail;
  logic finish_tmo;
  logic op_end;

  assign go = reg_write && reg_addr == fwsb_pkg::REG_CTRL && reg_wdata[fwsb_pkg::CTRL_GO_BIT] && !busy_reg;
  assign is_read = cmd_reg != fwsb_pkg::CMD_WRITE && cmd_reg != fwsb_pkg::CMD_RESET;

  // ****************************************
  // Operation events
  // ****************************************
  assign strobe_end = state_reg == fwsb_pkg::FWSB_STROBE && cyc_reg == 6'h0;
  assign hold_end = state_reg == fwsb_pkg::FWSB_HOLD && cyc_reg == 6'h0;
  assign single_end = hold_end && cmd_reg != fwsb_pkg::CMD_POLL;
  assign eval_now = state_reg == fwsb_pkg::FWSB_EVAL && !eval_wait_reg;
  assign finish_fail = eval_now && toggling && recheck_reg;
  // Poll count only grows on evaluations, so an endless toggle without the fail bit ends in a timeout
  assign finish_tmo = eval_now && toggling && !recheck_reg && poll_count_reg >= poll_limit_reg;
  assign op_end = single_end || (eval_now && !toggling) || finish_fail || finish_tmo;
  // Data polling compares bit 7 with the byte written; toggle polling with the last read
  assign cmp_ref = use_poll_reg ? wdata_reg : prev_reg;

  function automatic logic [5:0] phase_len(input logic rd);
    phase_len = rd ? fwsb_pkg::ACC_CYC : fwsb_pkg::WP_CYC;
  endfunction : phase_len

  fwsb_sync u_sync (
    .clock(clock),
    .clock_enable(clock_enable),
    .d(flash_dq_in),
    .q(dq_sync)
  );

  fwsb_cmp u_cmp (
    .clock(clock),
    .clock_enable(clock_enable),
    .load(hold_end && !first_reg),
    .use_poll_bit(use_poll_reg),
    .prev(cmp_ref),
    .curr(rdata_reg),
    .toggling(toggling),
    .fail_seen(fail_seen)
  );

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      addr_reg <= 19'h0;
      wdata_reg <= 8'h0;
      cmd_reg <= fwsb_pkg::CMD_WRITE;
      use_poll_reg <= 1'b0;
      poll_limit_reg <= fwsb_pkg::POLL_LIMIT_RST;
    end else if (clock_enable && reg_write && !busy_reg) begin
      case (reg_addr)
        fwsb_pkg::REG_ADDR: addr_reg <= reg_wdata[18:0];
        fwsb_pkg::REG_WDATA: wdata_reg <= reg_wdata[7:0];
        fwsb_pkg::REG_POLLS: poll_limit_reg <= reg_wdata;
        fwsb_pkg::REG_CTRL: begin
          cmd_reg <= reg_wdata[fwsb_pkg::CTRL_CMD_LSB +: 3];
          use_poll_reg <= reg_wdata[fwsb_pkg::CTRL_USE_POLL_BIT];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Register reads, data one cycle later
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (clock_enable) begin
      reg_rdata <= 32'h0;
      if (reg_read) begin
        case (reg_addr)
          fwsb_pkg::REG_CTRL: reg_rdata <= {26'h0, use_poll_reg, busy_reg, 1'b0, cmd_reg};
          fwsb_pkg::REG_ADDR: reg_rdata <= {13'h0, addr_reg};
          fwsb_pkg::REG_WDATA: reg_rdata <= {24'h0, wdata_reg};
          fwsb_pkg::REG_STATUS: reg_rdata <= {27'h0, timeout_reg, window_reg, fail_reg, done_reg, busy_reg};
          fwsb_pkg::REG_RDATA: reg_rdata <= {24'h0, rdata_reg};
          fwsb_pkg::REG_POLLS: reg_rdata <= poll_limit_reg;
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // Bus cycle sequencer
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= fwsb_pkg::FWSB_IDLE;
      cyc_reg <= 6'h0;
      first_reg <= 1'b1;
      recheck_reg <= 1'b0;
      eval_wait_reg <= 1'b0;
      poll_count_reg <= 32'h0;
    end else if (clock_enable) begin
      case (state_reg)
        fwsb_pkg::FWSB_IDLE: begin
          if (go) begin
            first_reg <= 1'b1;
            recheck_reg <= 1'b0;
            poll_count_reg <= 32'h0;
            state_reg <= fwsb_pkg::FWSB_SETUP;
          end
        end
        fwsb_pkg::FWSB_SETUP: begin
          cyc_reg <= phase_len(is_read);
          state_reg <= fwsb_pkg::FWSB_STROBE;
        end
        fwsb_pkg::FWSB_STROBE: begin
          if (cyc_reg != 6'h0) begin
            cyc_reg <= cyc_reg - 6'h1;
          end else begin
            cyc_reg <= fwsb_pkg::OEH_CYC;
            state_reg <= fwsb_pkg::FWSB_HOLD;
          end
        end
        fwsb_pkg::FWSB_HOLD: begin
          if (cyc_reg != 6'h0) begin
            cyc_reg <= cyc_reg - 6'h1;
          end else if (single_end) begin
            state_reg <= fwsb_pkg::FWSB_IDLE;
          end else if (first_reg) begin
            first_reg <= 1'b0;
            state_reg <= fwsb_pkg::FWSB_SETUP;
          end else begin
            // Compare result is registered, so give it one cycle
            eval_wait_reg <= 1'b1;
            state_reg <= fwsb_pkg::FWSB_EVAL;
          end
        end
        fwsb_pkg::FWSB_EVAL: begin
          eval_wait_reg <= 1'b0;
          if (eval_now) begin
            poll_count_reg <= poll_count_reg + 32'h1;
            if (op_end) begin
              state_reg <= fwsb_pkg::FWSB_IDLE;
            end else begin
              recheck_reg <= fail_seen;
              state_reg <= fwsb_pkg::FWSB_SETUP;
            end
          end
        end
        default: state_reg <= fwsb_pkg::FWSB_IDLE;
      endcase
    end
  end

  // ****************************************
  // Flash pins
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      flash_addr <= 19'h0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 8'h0;
      flash_dq_oe <= 1'b0;
    end else if (clock_enable) begin
      if (state_reg == fwsb_pkg::FWSB_SETUP) begin
        flash_addr <= addr_reg;
        flash_dq_out <= (cmd_reg == fwsb_pkg::CMD_RESET) ? fwsb_pkg::RESET_CMD_DATA : wdata_reg;
        flash_dq_oe <= !is_read;
        flash_ce_n <= 1'b0;
        flash_oe_n <= !is_read;
        flash_we_n <= is_read;
      end else if (strobe_end) begin
        // Each read ends with OE and CE rising so the flash sees a whole cycle
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b1;
      end else if (state_reg == fwsb_pkg::FWSB_HOLD) begin
        // Write data stays on the bus one cycle past the strobe for hold time
        flash_dq_oe <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read data capture
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_reg <= 8'h0;
      prev_reg <= 8'h0;
    end else if (clock_enable && strobe_end) begin
      prev_reg <= rdata_reg;
      if (is_read) begin
        rdata_reg <= dq_sync;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      window_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else if (clock_enable) begin
      // Start and end never meet: go needs idle, op_end needs a running operation
      if (go) begin
        busy_reg <= 1'b1;
        done_reg <= 1'b0;
        fail_reg <= 1'b0;
        timeout_reg <= 1'b0;
      end
      if (op_end) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
      if (finish_fail) begin
        fail_reg <= 1'b1;
      end
      if (finish_tmo) begin
        timeout_reg <= 1'b1;
      end
      if (single_end || eval_now) begin
        window_reg <= rdata_reg[fwsb_pkg::BIT_ERASE_WINDOW];
      end
    end
  end
endmodule : fwsb_host
`default_nettype wire

// file: testbench/fwsb_checker.sv
// Purpose: Port checks on the flash polling host.
// Assumes: One clock domain with a synchronous reset.
// Notes: Bound to every host instance.
`timescale 1ns/1ps
`default_nettype none
module fwsb_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [18:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_dq_oe
);
  // ****
  // Bus cycle shape and register read data
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence read_pulse;
    !flash_oe_n [*8];
  endsequence
  sequence bus_idle;
    flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe;
  endsequence
  strobe_excl_a: assert property (flash_oe_n || flash_we_n)
    else $error("read and write strobes overlap");
  // Driving dq while the part drives it would fight on the bus
  no_fight_a: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("data driven during a read");
  write_drive_a: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
    else $error("write strobe without data or select");
  addr_hold_a: assert property (!flash_ce_n ##1 !flash_ce_n |-> $stable(flash_addr))
    else $error("address moved inside a cycle");
  read_len_a: assert property ($fell(flash_oe_n) |-> read_pulse)
    else $error("read strobe too short");
  read_end_a: assert property ($fell(flash_oe_n) |-> ##[8:40] flash_oe_n)
    else $error("read strobe never released");
  write_len_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*8] ##[1:30] flash_we_n)
    else $error("write strobe length wrong");
  reset_idle_a: assert property ($fell(reset) |-> bus_idle)
    else $error("bus not idle after reset");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data without a read");
endmodule : fwsb_checker
bind fwsb_host fwsb_checker chk (.clock(clock), .reset(reset), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// file: testbench/fwsb_flash_model.sv
// Purpose: Behavioural NOR flash status model.
// Assumes: Bench sets the operation state by hierarchy.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module fwsb_flash_model (
  input wire logic [18:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] flash_dq_out,
  output logic [7:0] flash_dq_in
);
  int busy_reads = 0;
  // stuck with fail is a halted program; skipped sectors leave fail low
  bit stuck = 0, fail = 0, window = 0, t1 = 0, t2 = 0, suspend = 0, prog = 0;
  logic [7:0] arr = 8'h00, last = 8'h00, last_wd;
  logic [18:0] last_wa;
  wire rd_n = flash_ce_n | flash_oe_n;
  wire wr_n = flash_ce_n | flash_we_n;
  wire st = stuck || busy_reads > 0;
  // poll bit is the complement of the byte being programmed
  wire [7:0] val = st ? {prog ? ~arr[7] : 1'b0, t1, fail, 1'b0, window, t2, 2'b00} : arr;
  assign flash_dq_in = rd_n ? ~last : val;
  always @(posedge rd_n) begin
    last = val;
    // toggle one stands still in suspend
    if (st) begin
      if (!suspend) t1 = !t1;
      t2 = !t2;
    end
    // toggling for a while, then array data
    if (busy_reads > 0) busy_reads--;
  end
  // only the reset command is acted on
  always @(posedge wr_n) begin
    last_wa = flash_addr;
    last_wd = flash_dq_out;
    if (flash_dq_out == 8'hf0) begin
      stuck = 0;
      fail = 0;
      busy_reads = 0;
    end
  end
endmodule : fwsb_flash_model
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the flash polling host.
// Assumes: Clock enable held high except for one frozen register write.
// Notes: Addresses and data are random from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic clock_enable = 1'b1;
  logic poll_mode = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, s;
  logic [18:0] flash_addr, a;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  logic [7:0] flash_dq_in, flash_dq_out, d;
  int fail_count = 0;
  int n_tests = 0;
  int k;
  always #2.5 clock = ~clock;
  fwsb_host uut (.clock(clock), .reset(reset), .clock_enable(clock_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
  fwsb_flash_model fm (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] ad, output logic [31:0] dt);
    @(posedge clock);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    dt = reg_rdata;
  endtask : rd
  task op(input logic [2:0] cmd, output logic [31:0] st);
    int i;
    wr(fwsb_pkg::REG_CTRL, (32'h1 << fwsb_pkg::CTRL_GO_BIT) | (32'(poll_mode) << fwsb_pkg::CTRL_USE_POLL_BIT)
      | 32'(cmd));
    st = 32'h1;
    for (i = 0; i < 5000 && st[fwsb_pkg::ST_BUSY] !== 1'b0; i++) rd(fwsb_pkg::REG_STATUS, st);
    if (st[fwsb_pkg::ST_BUSY] !== 1'b0) begin
      check("busy wait", st, 32'h0);
      test_done();
    end
  endtask : op
  function automatic logic [4:0] exp_st(input logic fl, input logic tmo);
    exp_st = 5'h0;
    exp_st[fwsb_pkg::ST_DONE] = 1'b1;
    exp_st[fwsb_pkg::ST_FAIL] = fl;
    exp_st[fwsb_pkg::ST_TIMEOUT] = tmo;
  endfunction : exp_st
  initial begin
    void'($urandom(32'ha5673087));
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rd(fwsb_pkg::REG_STATUS, s);
    check("status after reset", s, 32'h0);
    rd(4'hf, s);
    check("unmapped read", s, 32'h0);
    for (k = 0; k < 4; k++) begin
      a = 19'($urandom);
      d = (k == 0) ? 8'hff : 8'($urandom);
      wr(fwsb_pkg::REG_ADDR, 32'(a));
      wr(fwsb_pkg::REG_WDATA, 32'(d));
      op(k[0] ? fwsb_pkg::CMD_RESET : fwsb_pkg::CMD_WRITE, s);
      check("write address", 32'(fm.last_wa), 32'(a));
      check("write data", 32'(fm.last_wd), k[0] ? 32'hf0 : 32'(d));
    end
    // Frozen clock enable must swallow a register write
    @(posedge clock);
    clock_enable <= 1'b0;
    wr(fwsb_pkg::REG_ADDR, 32'h0);
    @(posedge clock);
    clock_enable <= 1'b1;
    rd(fwsb_pkg::REG_ADDR, s);
    check("frozen address", s, 32'(a));
    d = 8'($urandom);
    fm.arr = d;
    op(fwsb_pkg::CMD_READ, s);
    rd(fwsb_pkg::REG_RDATA, s);
    check("array read", s, 32'(d));
    for (k = 0; k < 2; k++) begin
      fm.stuck = 1;
      fm.window = k[0];
      op(fwsb_pkg::CMD_WINDOW, s);
      check("window flag", 32'(s[fwsb_pkg::ST_WINDOW]), 32'(k[0]));
      op(fwsb_pkg::CMD_RESET, s);
    end
    // Short, long, limit failure, endless, data polling, suspended erase
    for (k = 0; k < 6; k++) begin
      fm.stuck = k == 2 || k == 3 || k == 5;
      fm.fail = k == 2;
      fm.prog = k == 4;
      fm.suspend = k == 5;
      poll_mode = k == 4;
      fm.busy_reads = (k == 0) ? 1 : (k == 1 || k == 4) ? 2 + $urandom % 4 : 0;
      wr(fwsb_pkg::REG_WDATA, 32'(fm.arr));
      wr(fwsb_pkg::REG_POLLS, (k == 3) ? 32'h4 : 32'h20);
      op(fwsb_pkg::CMD_POLL, s);
      check("poll status", 32'(s[4:0] & 5'h17), 32'(exp_st(k == 2, k == 3)));
      op(fwsb_pkg::CMD_RESET, s);
    end
    op(fwsb_pkg::CMD_POLL, s);
    check("poll after reset", 32'(s[4:0] & 5'h17), 32'(exp_st(1'b0, 1'b0)));
    test_done();
  end
endmodule : testbench
`default_nettype wire
